// ===== asl_host.sv
// Purpose: host side of the serial link: shift clock master and strobe driver
// Assumes: pclk at 100 MHz, shift clock period of 8 pclk (80 ns)
// Notes: shift clock idles low; config_in shows the inverse of its last bit outside frames
`timescale 1ns/100ps
module asl_host (
  input wire logic pclk,
  input wire logic result_out,
  output logic shift_clk,
  output logic config_in,
  output logic sample_start
);
  // idle levels at time zero
  initial begin
    shift_clk = 1'b0;
    config_in = 1'b0;
    sample_start = 1'b0;
  end

  // one full-duplex frame: 8 config bits then junk, 16 result bits back
  task automatic xfer(input logic [7:0] cfg, output logic [15:0] res);
    for (int i = 0; i < 16; i++) begin
      config_in <= (i < 8) ? cfg[7-i] : ~config_in;
      repeat (4) @(posedge pclk);
      // result bit is taken as the shift clock rises, settled since the last fall
      res[15-i] = result_out;
      shift_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      shift_clk <= 1'b0;
    end
    config_in <= ~config_in;
    repeat (6) @(posedge pclk);
  endtask

  // strobe held high 50 ns; between strobes the level stays put
  task automatic strobe();
    sample_start <= 1'b1;
    repeat (5) @(posedge pclk);
    sample_start <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

// ===== asl_link.sv
// Purpose: serial configuration and result link of a multiplexed converter
// Assumes: shift clock, data and strobes come from pins, sampled by pclk
// Notes: a software-written sample stands in for the analog code
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module asl_link
  import asl_pkg::*;
#(
  parameter int RES_BITS = WORD_BITS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic shift_clk,
  input wire logic config_in,
  input wire logic sample_start,
  input wire logic read_enable_n,
  output logic result_out,
  output logic result_out_oe,
  output logic done_n,
  output logic [2:0] mux_pos,
  output logic [2:0] mux_neg,
  output logic mux_neg_is_com,
  output logic one_sided_range,
  output logic wide_span,
  output logic nap_active,
  output logic sleep_active
);

  typedef struct packed {
    logic [7:0] cfg_shift;
    logic [7:0] cfg_word;
    logic [7:0] applied;
    logic [CNT_W-1:0] rise_cnt;
    logic [CNT_W-1:0] fall_cnt;
    logic [WORD_BITS-1:0] out_shift;
    logic [WORD_BITS-1:0] result;
    logic [WORD_BITS-1:0] sample;
    logic converting;
    logic [CONV_W-1:0] conv_cnt;
    asl_pwr_t pwr;
    logic wake_armed;
    logic [2:0] mux_pos;
    logic [2:0] mux_neg;
    logic neg_com;
    logic [31:0] prdata;
    logic pslverr;
  } asl_state_t;

  asl_state_t s;
  asl_state_t next_s;
  asl_sync_if sy ();

  logic sck_rise;
  logic sck_fall;
  logic start_rise;
  logic cfg_lvl;
  logic [7:0] next_word;

  // pin synchronisers and edge finders
  asl_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pins({read_enable_n, sample_start, config_in, shift_clk}),
    .sy(sy.src)
  );

  assign sck_rise = sy.rise[SYN_SCK];
  assign sck_fall = sy.fall[SYN_SCK];
  assign start_rise = sy.rise[SYN_START];
  assign cfg_lvl = sy.lvl[SYN_CFG];
  assign next_word = {s.cfg_shift[6:0], cfg_lvl};

  // multiplexer decode: {neg_is_com, neg, pos}
  function automatic logic [6:0] mux_decode(input logic [7:0] cfg);
    logic [1:0] sel;
    logic odd;
    sel = {cfg[CFG_SEL1], cfg[CFG_SEL0]};
    odd = cfg[CFG_ODD];
    if (cfg[CFG_SGL]) begin
      mux_decode = {1'b1, 3'h0, sel, odd};
    end else begin
      mux_decode = {1'b0, sel, ~odd, sel, odd};
    end
  endfunction

  // output coding and resolution masking of the raw offset-binary sample
  function automatic logic [WORD_BITS-1:0] code_format(
    input logic [WORD_BITS-1:0] raw,
    input logic [7:0] cfg
  );
    logic [WORD_BITS-1:0] code;
    code = raw;
    if (!cfg[CFG_UNI]) begin
      code[WORD_BITS-1] = ~raw[WORD_BITS-1];
    end
    for (int i = 0; i < WORD_BITS - RES_BITS; i++) begin
      code[i] = 1'b0;
    end
    code_format = code;
  endfunction

  // next state of the whole block
  always_comb begin
    next_s = s;

    // apb: read data and error latched in setup, writes in access
    if (psel && !penable) begin
      next_s.prdata = 32'h0000_0000;
      next_s.pslverr = 1'b0;
      if (paddr == ADDR_STATUS) begin
        next_s.prdata[ST_PWR_LSB +: 2] = s.pwr;
        next_s.prdata[ST_BUSY] = s.converting;
        next_s.prdata[ST_ARMED] = s.wake_armed;
        next_s.prdata[ST_APPLIED_LSB +: 8] = s.applied;
        next_s.prdata[ST_WORD_LSB +: 8] = s.cfg_word;
        next_s.prdata[ST_RISE_LSB +: CNT_W] = s.rise_cnt;
      end else if (paddr == ADDR_SAMPLE) begin
        next_s.prdata[WORD_BITS-1:0] = s.sample;
      end else begin
        next_s.pslverr = 1'b1;
      end
    end
    if (psel && penable && pwrite && paddr == ADDR_SAMPLE) begin
      next_s.sample = pwdata[WORD_BITS-1:0];
    end

    // conversion timer; result loads the shifter when done rises
    if (s.converting) begin
      next_s.conv_cnt = s.conv_cnt + 1'b1;
      if (s.conv_cnt == CONV_W'(CONV_CYCLES - 1)) begin
        next_s.converting = 1'b0;
        next_s.result = code_format(s.sample, s.applied);
        next_s.out_shift = next_s.result;
        if (s.applied[CFG_NAP] && s.pwr == PWR_ON) begin
          next_s.pwr = PWR_NAP;
        end
      end
    end

    // rising shift edge: capture up to eight config bits, msb first
    if (sck_rise) begin
      if (s.rise_cnt < CNT_W'(CFG_BITS)) begin
        next_s.cfg_shift = next_word;
        if (s.rise_cnt == CNT_W'(CFG_BITS - 1)) begin
          next_s.cfg_word = next_word;
        end
      end
      if (s.rise_cnt != '1) begin
        next_s.rise_cnt = s.rise_cnt + 1'b1;
      end
    end

    // falling shift edge: advance result, handle power changes
    if (sck_fall) begin
      next_s.out_shift = {s.out_shift[WORD_BITS-2:0], 1'b0};
      if (s.fall_cnt != '1) begin
        next_s.fall_cnt = s.fall_cnt + 1'b1;
      end
      if (s.pwr == PWR_NAP && s.fall_cnt == CNT_W'(NAP_EXIT_FALL - 1)) begin
        next_s.pwr = PWR_ON;
      end
      if (s.fall_cnt == CNT_W'(SLEEP_FALL - 1)) begin
        if (s.cfg_word[CFG_SLEEP]) begin
          next_s.pwr = PWR_SLEEP;
        end else if (s.pwr == PWR_SLEEP && s.wake_armed) begin
          next_s.pwr = PWR_ON;
          next_s.wake_armed = 1'b0;
        end
      end
    end

    // strobe when not busy: restart the edge counters, convert unless asleep
    if (start_rise && !s.converting) begin
      next_s.rise_cnt = '0;
      next_s.fall_cnt = '0;
      if (s.pwr == PWR_SLEEP) begin
        next_s.wake_armed = 1'b1;
      end else begin
        next_s.converting = 1'b1;
        next_s.conv_cnt = '0;
        next_s.applied = s.cfg_word;
        {next_s.neg_com, next_s.mux_neg, next_s.mux_pos} =
          mux_decode(s.cfg_word);
      end
    end
  end

  // one register for the whole state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.cfg_word <= CFG_RESET;
      s.applied <= CFG_RESET;
      s.sample <= SAMPLE_RESET;
      s.pwr <= PWR_ON;
    end else begin
      s <= next_s;
    end
  end

  // outputs
  assign prdata = s.prdata;
  assign pready = 1'b1;
  assign pslverr = s.pslverr;
  assign result_out = s.out_shift[WORD_BITS-1];
  assign result_out_oe = ~sy.lvl[SYN_RD];
  assign done_n = ~s.converting;
  assign mux_pos = s.mux_pos;
  assign mux_neg = s.mux_neg;
  assign mux_neg_is_com = s.neg_com;
  assign one_sided_range = s.applied[CFG_UNI];
  assign wide_span = s.applied[CFG_GAIN];
  assign nap_active = (s.pwr == PWR_NAP);
  assign sleep_active = (s.pwr == PWR_SLEEP);

  // checks on the link behaviour
  localparam int A_CONV = CONV_CYCLES;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence conv_start_s;
    start_rise && !s.converting && s.pwr != PWR_SLEEP;
  endsequence

  sequence conv_end_s;
    $rose(done_n);
  endsequence

  a_done_held_low: assert property (
    conv_start_s |=> (!done_n) [*8]
  ) else $error("done rose too early after a start");

  a_conv_length: assert property (
    $fell(done_n) |-> ##[1:A_CONV] conv_end_s
  ) else $error("conversion did not end in time");

  a_cfg_ignored: assert property (
    sck_rise && !start_rise && s.rise_cnt >= CNT_W'(CFG_BITS) |=> $stable(s.cfg_word)
      && s.cfg_shift == $past(s.cfg_shift)
  ) else $error("config captured past the eighth edge");

  a_cfg_order: assert property (
    sck_rise && !start_rise && s.rise_cnt == CNT_W'(CFG_BITS - 1)
      |=> s.cfg_word == {$past(s.cfg_shift[6:0]), $past(cfg_lvl)}
  ) else $error("config word not assembled msb first");

  a_result_loaded: assert property (
    conv_end_s |-> result_out == s.result[WORD_BITS-1]
      && s.out_shift == s.result
  ) else $error("result not presented after conversion");

  a_nap_entry: assert property (
    conv_end_s and ($past(s.pwr) == PWR_ON && s.applied[CFG_NAP]) |-> nap_active
  ) else $error("nap not entered when done rose");

  a_nap_exit: assert property (
    nap_active && sck_fall && s.fall_cnt == CNT_W'(NAP_EXIT_FALL - 1)
      |=> !nap_active
  ) else $error("nap not left on second falling edge");

  a_sleep_entry: assert property (
    sck_fall && !start_rise && s.cfg_word[CFG_SLEEP]
      && s.fall_cnt == CNT_W'(SLEEP_FALL - 1) |=> sleep_active
  ) else $error("sleep not entered on sixteenth edge");

  a_sleep_no_conv: assert property (
    sleep_active && start_rise |=> done_n ##1 done_n
  ) else $error("conversion started while asleep");

  a_mux_single: assert property (
    conv_start_s and s.cfg_word[CFG_SGL] |=> mux_neg_is_com
      && mux_pos == {s.applied[CFG_SEL1], s.applied[CFG_SEL0], s.applied[CFG_ODD]}
  ) else $error("single-ended channel decode wrong");

  a_out_enable: assert property (
    $fell(sy.lvl[SYN_RD]) |-> result_out_oe ##1 result_out_oe || $rose(sy.lvl[SYN_RD])
  ) else $error("result output not enabled by read enable");

endmodule

// ===== asl_pkg.sv
// Purpose: shared constants and types of the converter serial link
// Assumes: pclk at 100 MHz, APB with 32-bit data
// Notes: configuration bits are numbered with the first received bit at 7
package asl_pkg;

  // configuration word layout, first received bit is the msb
  localparam int CFG_BITS = 8;
  localparam int CFG_SGL = 7;
  localparam int CFG_ODD = 6;
  localparam int CFG_SEL1 = 5;
  localparam int CFG_SEL0 = 4;
  localparam int CFG_UNI = 3;
  localparam int CFG_GAIN = 2;
  localparam int CFG_NAP = 1;
  localparam int CFG_SLEEP = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // result word and shift clock edge counting
  localparam int WORD_BITS = 16;
  localparam int CNT_W = 5;
  localparam int NAP_EXIT_FALL = 2;
  localparam int SLEEP_FALL = 16;

  // conversion time, rounded up to whole pclk cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS = 4000;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_W = 10;

  // apb register map
  localparam int APB_AW = 8;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_SAMPLE = 8'h04;
  localparam logic [15:0] SAMPLE_RESET = 16'h8000;
  localparam int ST_PWR_LSB = 0;
  localparam int ST_BUSY = 2;
  localparam int ST_ARMED = 3;
  localparam int ST_APPLIED_LSB = 8;
  localparam int ST_WORD_LSB = 16;
  localparam int ST_RISE_LSB = 24;

  // synchronised pin indices
  localparam int SYN_N = 4;
  localparam int SYN_SCK = 0;
  localparam int SYN_CFG = 1;
  localparam int SYN_START = 2;
  localparam int SYN_RD = 3;

  typedef enum logic [1:0] {PWR_ON, PWR_NAP, PWR_SLEEP} asl_pwr_t;

endpackage

// ===== asl_sync.sv
// Purpose: two-flop synchronisers and edge detection for the link pins
// Assumes: pins are asynchronous to pclk
// Notes: edges are seen one to two pclk cycles after the pin moves
`timescale 1ns/100ps
module asl_sync
  import asl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [SYN_N-1:0] pins,
  asl_sync_if.src sy
);

  typedef struct packed {
    logic [SYN_N-1:0] meta;
    logic [SYN_N-1:0] stable;
    logic [SYN_N-1:0] prev;
  } asl_sync_state_t;

  asl_sync_state_t s;
  asl_sync_state_t next_s;

  // first stage feeds only the second stage
  always_comb begin
    next_s = s;
    next_s.meta = pins;
    next_s.stable = s.meta;
    next_s.prev = s.stable;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // edges compare the stable stage with its delayed copy
  genvar i;
  generate
    for (i = 0; i < SYN_N; i++) begin : g_edge
      assign sy.lvl[i] = s.stable[i];
      assign sy.rise[i] = s.stable[i] & ~s.prev[i];
      assign sy.fall[i] = ~s.stable[i] & s.prev[i];
    end
  endgenerate

endmodule

// ===== asl_sync_if.sv
// Purpose: carries synchronised pin levels and their edges
// Assumes: all signals on pclk
// Notes: one bit per pin, indexed by the SYN_ constants
`timescale 1ns/100ps
interface asl_sync_if;
  import asl_pkg::*;
  logic [SYN_N-1:0] lvl;
  logic [SYN_N-1:0] rise;
  logic [SYN_N-1:0] fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface

// ===== asl_tb.sv
// Purpose: self-checking bench of the converter serial link
// Assumes: pclk 100 MHz, 12-bit result variant, host model drives the link
// Notes: every scenario is its own task; end_of_test gives the verdict
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin err_total++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
module testbench;
  import asl_pkg::*;
  localparam int RB = 12;
  localparam logic [15:0] MASK = 16'hffff << (WORD_BITS - RB);
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic shift_clk;
  logic config_in;
  logic sample_start;
  logic read_enable_n = 1'b0;
  logic result_out;
  logic result_out_oe;
  logic done_n;
  logic [2:0] mux_pos;
  logic [2:0] mux_neg;
  logic mux_neg_is_com;
  logic one_sided_range;
  logic wide_span;
  logic nap_active;
  logic sleep_active;
  int err_total = 0;
  int cmp_count = 0;
  int low_cnt = 0;
  logic [31:0] rd;
  logic er;
  logic [15:0] res;
  logic [15:0] exp_res;

  asl_link #(.RES_BITS(RB)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .shift_clk(shift_clk), .config_in(config_in),
    .sample_start(sample_start), .read_enable_n(read_enable_n), .result_out(result_out),
    .result_out_oe(result_out_oe), .done_n(done_n), .mux_pos(mux_pos), .mux_neg(mux_neg),
    .mux_neg_is_com(mux_neg_is_com), .one_sided_range(one_sided_range),
    .wide_span(wide_span), .nap_active(nap_active), .sleep_active(sleep_active));

  asl_host host (.pclk(pclk), .result_out(result_out), .shift_clk(shift_clk),
    .config_in(config_in), .sample_start(sample_start));

  // clock and a running count of cycles spent converting
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (done_n === 1'b0) low_cnt <= low_cnt + 1;

  // verdict and end of run
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // strobe, optional restart 100 cycles later, then wait for done and count busy cycles
  task automatic convert(input bit restart);
    int c0;
    c0 = low_cnt;
    host.strobe();
    if (restart) begin
      repeat (100) @(posedge pclk);
      host.strobe();
    end
    while (done_n !== 1'b1) begin
      @(posedge pclk);
    end
    repeat (2) @(posedge pclk);
    `CHK("done_low_cycles", CONV_CYCLES, low_cnt - c0)
  endtask

  // idle levels, output enable, sample register and an unmapped address
  task automatic t_reset();
    `CHK("done_idle", 1'b1, done_n)
    `CHK("sleep_idle", 1'b0, sleep_active)
    `CHK("oe_enabled", 1'b1, result_out_oe)
    read_enable_n <= 1'b1;
    repeat (5) @(posedge pclk);
    `CHK("oe_disabled", 1'b0, result_out_oe)
    read_enable_n <= 1'b0;
    apb(1'b0, ADDR_SAMPLE, 32'h0000_0000, rd, er);
    `CHK("sample_reset", {16'h0000, SAMPLE_RESET}, rd)
    apb(1'b0, 8'h08, 32'h0000_0000, rd, er);
    `CHK("unmapped_err", 1'b1, er)
  endtask

  // every mux code with range and span bits, result checked one exchange later
  task automatic t_modes();
    logic [3:0] k;
    logic [15:0] smp;
    for (int i = 0; i < 16; i++) begin
      k = i[3:0];
      smp = 16'h1357 + 16'h1111 * {12'h000, k};
      apb(1'b1, ADDR_SAMPLE, {16'h0000, smp}, rd, er);
      host.xfer({k, k[0], k[1], 2'b00}, res);
      if (i > 0) `CHK("result", exp_res, res)
      exp_res = (smp ^ (k[0] ? 16'h0000 : 16'h8000)) & MASK;
      convert(i == 5);
      `CHK("mux_pos", {k[1:0], k[2]}, mux_pos)
      `CHK("mux_neg", k[3] ? 3'b000 : {k[1:0], ~k[2]}, mux_neg)
      `CHK("neg_is_com", k[3], mux_neg_is_com)
      `CHK("range", k[0], one_sided_range)
      `CHK("span", k[1], wide_span)
      `CHK("no_nap", 1'b0, nap_active)
    end
  endtask

  // nap after a conversion, then sleep, a strobe while asleep, and wake
  task automatic t_power();
    int c0;
    host.xfer(8'h02, res);
    `CHK("result_nap", exp_res, res)
    exp_res = exp_res ^ 16'h8000;
    convert(1'b0);
    `CHK("nap_on", 1'b1, nap_active)
    host.xfer(8'h03, res);
    `CHK("result_sleep", exp_res, res)
    `CHK("nap_off", 1'b0, nap_active)
    `CHK("sleep_on", 1'b1, sleep_active)
    c0 = low_cnt;
    host.strobe();
    repeat (20) @(posedge pclk);
    `CHK("no_conv_asleep", 0, low_cnt - c0)
    host.xfer(8'h00, res);
    `CHK("sleep_off", 1'b0, sleep_active)
    // reference settling time after wake, scaled down to keep the run short
    repeat (50) @(posedge pclk);
    convert(1'b0);
    `CHK("power_on", 1'b0, nap_active)
  endtask

  // watchdog, well beyond the roughly 10k cycles the run needs
  initial begin
    #500_000;
    err_total++;
    end_of_test();
  end

  // reset, then the scenarios in turn
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_reset();
    t_modes();
    t_power();
    end_of_test();
  end
endmodule
